// ==== hdl/fbs_pkg.sv ====
// package of constants and types for the fieldbus slave status and value logic
package fbs_pkg;

  // ---------------------------------------------------------------------------
  // bit rates
  // ---------------------------------------------------------------------------
  // rate codes 0..9 stand for 9.6 kBd up to the top rate of 12 MBd
  localparam int unsigned FBS_RATE_CODE_W = 4;
  localparam logic [3:0] FBS_RATE_CODE_MAX = 4'h9;

  // ---------------------------------------------------------------------------
  // value encoding
  // ---------------------------------------------------------------------------
  localparam int unsigned FBS_VAL_W = 16;
  localparam int unsigned FBS_SHIFT_W = 2;
  // raw values carry three decimal fraction digits
  localparam logic signed [31:0] FBS_RAW_DIV_0 = 32'sh000003e8;
  localparam logic signed [31:0] FBS_RAW_DIV_1 = 32'sh00000064;
  localparam logic signed [31:0] FBS_RAW_DIV_2 = 32'sh0000000a;
  localparam logic signed [31:0] FBS_RAW_DIV_3 = 32'sh00000001;
  // percent raw is in thousandths of a percent, sent as hundredths
  localparam logic signed [31:0] FBS_PCT_DIV = 32'sh0000000a;
  localparam logic signed [15:0] FBS_CODE_OVER = 16'sh7fff;
  localparam logic signed [15:0] FBS_CODE_UNDER = 16'sh8000;
  localparam logic signed [15:0] FBS_CODE_INVALID = 16'sh8001;
  localparam logic signed [31:0] FBS_NUM_MAX = 32'sh00007ffe;
  localparam logic signed [31:0] FBS_NUM_MIN = 32'shffff8002;

  typedef enum logic [1:0] {
    FBS_KIND_PLAIN = 2'b00,
    FBS_KIND_SETPOINT = 2'b01,
    FBS_KIND_INPUT = 2'b10,
    FBS_KIND_PERCENT = 2'b11
  } fbs_kind_t;

  // ---------------------------------------------------------------------------
  // initialization stages and indicators
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    FBS_ST_BAUD_HUNT = 2'b00,
    FBS_ST_WAIT_PRM = 2'b01,
    FBS_ST_WAIT_CFG = 2'b10,
    FBS_ST_DATA_EXCH = 2'b11
  } fbs_state_t;

  localparam int unsigned FBS_LED_RED = 0;
  localparam int unsigned FBS_LED_YELLOW = 1;
  localparam int unsigned FBS_LED_GREEN = 2;

endpackage : fbs_pkg

// ==== hdl/fbs_enc_if.sv ====
// interface between the stage controller and the value encoder
`timescale 1ns/1ns
interface fbs_enc_if;
  import fbs_pkg::*;
  logic start;
  logic signed [31:0] raw;
  fbs_kind_t kind;
  logic over;
  logic under;
  logic invalid;
  logic [FBS_SHIFT_W-1:0] sp_shift;
  logic [FBS_SHIFT_W-1:0] in_shift;
  logic done;
  logic signed [FBS_VAL_W-1:0] code;

  modport enc (
    input start, raw, kind, over, under, invalid, sp_shift, in_shift,
    output done, code
  );
  modport ctl (
    output start, raw, kind, over, under, invalid, sp_shift, in_shift,
    input done, code
  );
endinterface : fbs_enc_if

// ==== hdl/fbs_value_enc.sv ====
// value encoder: scales a raw process value into a signed 16-bit word
`timescale 1ns/1ns
module fbs_value_enc
  import fbs_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  fbs_enc_if.enc enc
);

  typedef struct packed {
    logic done;
    logic signed [FBS_VAL_W-1:0] code;
  } fbs_enc_state_t;

  fbs_enc_state_t st_r;
  fbs_enc_state_t st_nxt;

  // divisor that leaves the requested number of fraction digits
  function automatic logic signed [31:0] fbs_shift_div(input logic [FBS_SHIFT_W-1:0] sh);
    logic signed [31:0] d;
    d = FBS_RAW_DIV_0;
    unique case (sh)
      2'h0: d = FBS_RAW_DIV_0;
      2'h1: d = FBS_RAW_DIV_1;
      2'h2: d = FBS_RAW_DIV_2;
      2'h3: d = FBS_RAW_DIV_3;
    endcase
    return d;
  endfunction : fbs_shift_div

  // ---------------------------------------------------------------------------
  // scaling and error substitution
  // ---------------------------------------------------------------------------
  always_comb begin
    logic signed [31:0] q;
    q = 32'sh00000000;
    st_nxt = st_r;
    st_nxt.done = enc.start;
    unique case (enc.kind)
      FBS_KIND_PLAIN: q = enc.raw / FBS_RAW_DIV_0;
      FBS_KIND_SETPOINT: q = enc.raw / fbs_shift_div(enc.sp_shift);
      FBS_KIND_INPUT: q = enc.raw / fbs_shift_div(enc.in_shift);
      FBS_KIND_PERCENT: q = enc.raw / FBS_PCT_DIV;
    endcase
    if (enc.start) begin
      // invalid wins over range flags; out-of-range numbers fold into the codes
      if (enc.invalid) begin
        st_nxt.code = FBS_CODE_INVALID;
      end else if (enc.over || q > FBS_NUM_MAX) begin
        st_nxt.code = FBS_CODE_OVER;
      end else if (enc.under || q < FBS_NUM_MIN) begin
        st_nxt.code = FBS_CODE_UNDER;
      end else begin
        st_nxt.code = q[FBS_VAL_W-1:0];
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign enc.done = st_r.done;
  assign enc.code = st_r.code;

endmodule : fbs_value_enc

// ==== hdl/fbs_slave.sv ====
// fieldbus slave top: initialization stages, indicators and cyclic value answers
`timescale 1ns/1ns
module fbs_slave
  import fbs_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_iface_present,
  input wire logic i_rate_lock,
  input wire logic [FBS_RATE_CODE_W-1:0] i_rate_code,
  input wire logic i_prm_ok,
  input wire logic i_cfg_ok,
  input wire logic [FBS_SHIFT_W-1:0] i_setpoint_decimal_shift,
  input wire logic [FBS_SHIFT_W-1:0] i_input_decimal_shift,
  input wire logic i_dx_req,
  input wire logic signed [31:0] i_dx_raw,
  input wire logic [1:0] i_dx_kind,
  input wire logic i_dx_over,
  input wire logic i_dx_under,
  input wire logic i_dx_invalid,
  output logic o_resp_valid,
  output logic signed [FBS_VAL_W-1:0] o_resp_value,
  output logic o_dx_refused,
  output logic o_dx_active,
  output logic [2:0] o_led
);

  typedef struct packed {
    fbs_state_t stage;
    logic refused;
    logic [2:0] led;
  } fbs_top_state_t;

  fbs_top_state_t st_r;
  fbs_top_state_t st_nxt;
  logic rate_ok;
  logic accept;

  fbs_enc_if enc_if ();

  // a rate code outside the standard table is treated as no signal at all
  assign rate_ok = i_rate_lock && (i_rate_code <= FBS_RATE_CODE_MAX);

  // answers are only produced for a master request in data exchange
  assign accept = i_dx_req && (st_r.stage == FBS_ST_DATA_EXCH);

  // ---------------------------------------------------------------------------
  // encoder hookup
  // ---------------------------------------------------------------------------
  assign enc_if.start = accept;
  assign enc_if.raw = i_dx_raw;
  assign enc_if.kind = fbs_kind_t'(i_dx_kind);
  assign enc_if.over = i_dx_over;
  assign enc_if.under = i_dx_under;
  assign enc_if.invalid = i_dx_invalid;
  assign enc_if.sp_shift = i_setpoint_decimal_shift;
  assign enc_if.in_shift = i_input_decimal_shift;

  fbs_value_enc u_enc (
    .i_sys_clk(i_sys_clk),
    .i_resetn(i_resetn),
    .enc(enc_if.enc)
  );

  // ---------------------------------------------------------------------------
  // initialization stage machine
  // ---------------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.refused = i_dx_req && !accept; // requests before data exchange get no answer
    unique case (st_r.stage)
      FBS_ST_BAUD_HUNT: begin
        // hunting only ends once the interface hardware is seen with a good rate
        if (i_iface_present && rate_ok) begin
          st_nxt.stage = FBS_ST_WAIT_PRM;
        end
      end
      FBS_ST_WAIT_PRM: begin
        if (!rate_ok || !i_iface_present) begin
          st_nxt.stage = FBS_ST_BAUD_HUNT;
        end else if (i_prm_ok) begin
          st_nxt.stage = FBS_ST_WAIT_CFG;
        end
      end
      FBS_ST_WAIT_CFG: begin
        if (!rate_ok || !i_iface_present) begin
          st_nxt.stage = FBS_ST_BAUD_HUNT;
        end else if (i_cfg_ok) begin
          st_nxt.stage = FBS_ST_DATA_EXCH;
        end
      end
      FBS_ST_DATA_EXCH: begin
        // a fresh parameter telegram forces a new configuration round
        if (!rate_ok || !i_iface_present) begin
          st_nxt.stage = FBS_ST_BAUD_HUNT;
        end else if (i_prm_ok) begin
          st_nxt.stage = FBS_ST_WAIT_CFG;
        end
      end
    endcase
    // indicators follow the next stage so they change with it, one lit at a time
    st_nxt.led = 3'h0;
    unique case (st_nxt.stage)
      FBS_ST_BAUD_HUNT: st_nxt.led[FBS_LED_RED] = 1'b1;
      FBS_ST_WAIT_PRM: st_nxt.led[FBS_LED_YELLOW] = 1'b1;
      FBS_ST_WAIT_CFG: st_nxt.led[FBS_LED_YELLOW] = 1'b1;
      FBS_ST_DATA_EXCH: st_nxt.led[FBS_LED_GREEN] = 1'b1;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      st_r.stage <= FBS_ST_BAUD_HUNT;
      st_r.refused <= 1'b0;
      st_r.led <= 3'h1; // red lit out of reset
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------------------
  assign o_resp_valid = enc_if.done;
  assign o_resp_value = enc_if.code;
  assign o_dx_refused = st_r.refused;
  assign o_dx_active = (st_r.stage == FBS_ST_DATA_EXCH);
  assign o_led = st_r.led;

endmodule : fbs_slave

// ==== verification/fbs_slave_monitor.sv ====
// assertion checker on the fieldbus slave top ports
`timescale 1ns/1ns
module fbs_slave_monitor
  import fbs_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_resetn,
  input wire logic i_rate_lock,
  input wire logic [FBS_RATE_CODE_W-1:0] i_rate_code,
  input wire logic i_iface_present,
  input wire logic i_cfg_ok,
  input wire logic i_dx_req,
  input wire logic i_dx_invalid,
  input wire logic o_resp_valid,
  input wire logic signed [FBS_VAL_W-1:0] o_resp_value,
  input wire logic o_dx_refused,
  input wire logic o_dx_active,
  input wire logic [2:0] o_led
);
  // ---------------------------------------------------------------------------
  // stage and answer checks
  // ---------------------------------------------------------------------------
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_resetn);

  led_one_hot_a: assert property ($onehot(o_led))
    else $error("indicator not one-hot");
  red_off_a: assert property (o_led[0] && i_iface_present && i_rate_lock
    && i_rate_code <= 4'h9 |=> !o_led[0]) else $error("red stays lit after lock");
  lost_lock_a: assert property (!o_led[0] && !i_rate_lock |=> o_led[0])
    else $error("no return to rate hunting");
  green_dx_a: assert property (o_dx_active == o_led[2])
    else $error("green and data exchange disagree");
  dx_after_cfg_a: assert property ($rose(o_dx_active) |-> $past(i_cfg_ok))
    else $error("data exchange without configuration");
  answer_now_a: assert property (i_dx_req && o_dx_active |=> o_resp_valid && !o_dx_refused)
    else $error("accepted request not answered");
  refuse_now_a: assert property (i_dx_req && !o_dx_active |=> o_dx_refused && !o_resp_valid)
    else $error("request outside exchange not refused");
  no_unasked_a: assert property (o_resp_valid |-> $past(i_dx_req))
    else $error("answer without request");
  invalid_code_a: assert property (i_dx_req && o_dx_active && i_dx_invalid
    |=> o_resp_value == 16'sh8001) else $error("invalid code wrong");

  cover property (o_dx_refused);
  cover property ($rose(o_dx_active));
  cover property (o_resp_valid && o_resp_value == 16'sh7fff);
endmodule : fbs_slave_monitor

bind fbs_slave fbs_slave_monitor fbs_slave_monitor_i (.i_sys_clk, .i_resetn, .i_rate_lock,
  .i_rate_code, .i_iface_present, .i_cfg_ok, .i_dx_req, .i_dx_invalid, .o_resp_valid,
  .o_resp_value, .o_dx_refused, .o_dx_active, .o_led);

// ==== verification/fbs_master_model.sv ====
// bus master model: rate lock and telegram pulses seen by the slave
`timescale 1ns/1ns
module fbs_master_model (
  input wire logic i_sys_clk,
  output logic o_rate_lock,
  output logic [3:0] o_rate_code,
  output logic o_prm_ok,
  output logic o_cfg_ok
);
  // idle: no lock, code out of range so a stale value cannot look valid
  initial begin
    o_rate_lock = 1'b0;
    o_rate_code = 4'hf;
    o_prm_ok = 1'b0;
    o_cfg_ok = 1'b0;
  end

  // set the rate lock and any 4-bit rate code, including codes above the 12 megabaud top rate
  task automatic lock(input logic on, input logic [3:0] code);
    @(posedge i_sys_clk);
    #2;
    o_rate_lock = on;
    o_rate_code = code;
  endtask : lock

  // one-cycle telegram pulse; configuration when cfg is set, parameters otherwise
  task automatic pulse(input logic cfg);
    @(posedge i_sys_clk);
    #2;
    if (cfg) o_cfg_ok = 1'b1;
    else o_prm_ok = 1'b1;
    @(posedge i_sys_clk);
    #2;
    o_prm_ok = 1'b0;
    o_cfg_ok = 1'b0;
  endtask : pulse
endmodule : fbs_master_model

// ==== verification/tb.sv ====
// self-checking bench for the fieldbus slave top
`timescale 1ns/1ns
module tb;
  import fbs_pkg::*;
  logic clk, rstn, pres, req, ov, un, inv, rv, rf, act, lk, po, co;
  logic [3:0] rc;
  logic [1:0] sps, ins, kd;
  logic signed [31:0] raw;
  logic signed [15:0] val;
  logic [2:0] led;
  logic [16:0] exp_q[$];
  logic [31:0] lf = 32'h000132e3; // seed 78563
  int n_errors = 0;
  int tests_run = 0;
  int dv[4] = '{1000, 100, 10, 1};

  fbs_slave fbs_slave_i (.i_sys_clk(clk), .i_resetn(rstn), .i_iface_present(pres),
    .i_rate_lock(lk), .i_rate_code(rc), .i_prm_ok(po), .i_cfg_ok(co),
    .i_setpoint_decimal_shift(sps), .i_input_decimal_shift(ins), .i_dx_req(req),
    .i_dx_raw(raw), .i_dx_kind(kd), .i_dx_over(ov), .i_dx_under(un), .i_dx_invalid(inv),
    .o_resp_valid(rv), .o_resp_value(val), .o_dx_refused(rf), .o_dx_active(act), .o_led(led));
  fbs_master_model fbs_master_model_i (.i_sys_clk(clk), .o_rate_lock(lk), .o_rate_code(rc),
    .o_prm_ok(po), .o_cfg_ok(co));

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic end_of_test();
    if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [16:0] s, input logic [16:0] e);
    tests_run++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nxt

  // expected word; flags f = {under, over, invalid}, invalid wins first
  function automatic logic [15:0] enc(input logic signed [31:0] r, input logic [1:0] k,
    input logic [2:0] f);
    logic signed [31:0] q;
    q = (k == 2'h3) ? r / 10 : (k == 2'h0) ? r / 1000 : r / dv[(k == 2'h1) ? sps : ins];
    if (f[0]) return 16'h8001;
    if (f[1] || q > 32766) return 16'h7fff;
    if (f[2] || q < -32766) return 16'h8000;
    return q[15:0];
  endfunction : enc

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : wt

  // request held high between back-to-back calls; shifts move with it
  task automatic ask(input logic signed [31:0] r, input logic [1:0] k, input logic [2:0] f,
    input logic [3:0] s);
    @(posedge clk);
    #2;
    {req, raw, kd, un, ov, inv, sps, ins} = {1'b1, r, k, f, s};
    exp_q.push_back(act ? {1'b0, enc(r, k, f)} : 17'h10000);
  endtask : ask

  task automatic idle();
    wt(1);
    req = 1'b0;
    wt(3);
  endtask : idle

  // answers are matched against the oldest note once settled
  always @(posedge clk) begin
    #1;
    if (rv || rf) begin
      if (exp_q.size() == 0) chk("extra", 17'h1, 17'h0);
      else chk("answer", rf ? 17'h10000 : {1'b0, val}, exp_q.pop_front());
    end
  end

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    {rstn, pres, req, raw, kd, un, ov, inv, sps, ins} = '0;
    wt(10);
    rstn = 1'b1;
    chk("led", 17'(led), 17'h1);
    ask(32'sd5, 2'h0, 3'h0, 4'h0);
    idle();
    fbs_master_model_i.lock(1'b1, 4'h9);
    wt(2);
    chk("led", 17'(led), 17'h1);
    // bad code goes up before presence, so a good code never meets presence
    fbs_master_model_i.lock(1'b1, 4'ha);
    pres = 1'b1;
    wt(2);
    chk("led", 17'(led), 17'h1);
    fbs_master_model_i.lock(1'b1, 4'h9);
    wt(2);
    chk("led", 17'(led), 17'h2);
    fbs_master_model_i.pulse(1'b1);
    wt(1);
    chk("led", 17'(led), 17'h2);
    fbs_master_model_i.pulse(1'b0);
    wt(1);
    chk("led", 17'(led), 17'h2);
    fbs_master_model_i.pulse(1'b1);
    wt(1);
    chk("led", {act, 13'h0, led}, 17'h10004);
    ask(32'sd1000, 2'h0, 3'h7, 4'h0);
    ask(32'sd0, 2'h1, 3'h2, 4'h0);
    ask(32'sd0, 2'h2, 3'h4, 4'h0);
    ask(32'sd32767000, 2'h0, 3'h0, 4'h0);
    ask(-32'sd32767000, 2'h0, 3'h0, 4'h0);
    ask(32'sd32766000, 2'h0, 3'h0, 4'h0);
    ask(32'sd42780, 2'h3, 3'h0, 4'h0);
    ask(32'sd25400, 2'h1, 3'h0, 4'h4);
    for (int i = 0; i < 64; i++) begin
      lf = nxt(lf);
      ask($signed(lf) >>> 9, lf[1:0], lf[6:4] & {3{lf[7] & lf[8]}}, lf[12:9]);
    end
    idle();
    fbs_master_model_i.pulse(1'b0);
    wt(1);
    chk("led", 17'(led), 17'h2);
    ask(32'sd7, 2'h0, 3'h0, 4'h0);
    idle();
    fbs_master_model_i.lock(1'b0, 4'h5);
    wt(2);
    chk("led", 17'(led), 17'h1);
    chk("pending", 17'(exp_q.size()), 17'h0);
    end_of_test();
  end
endmodule : tb
